// ===== hw/reset_control_defines.svh
// reset control unit: register offsets, field positions, reset values, timing
// assumes a 25 MHz hclk and a 32-bit AHB-Lite register port
`ifndef RESET_CONTROL_DEFINES_SVH
`define RESET_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_RESET_CAUSE 12'h000
`define OFS_BROWNOUT_CTL 12'h004
`define OFS_PERIPH_RESET0 12'h008
`define OFS_PERIPH_RESET1 12'h00C
`define OFS_PERIPH_RESET2 12'h010
`define OFS_CORE_IRQ_RESET_CTL 12'h014
`define OFS_STATUS 12'h018

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CAUSE_EXT_BIT 0
`define CAUSE_POR_BIT 1
`define CAUSE_BOR_BIT 2
`define CAUSE_WDT_BIT 3
`define CAUSE_SW_BIT 4
`define BOR_IRQ_EN_BIT 0
`define BOR_RESET_SEL_BIT 1
`define SYSTEM_RESET_REQUEST_BIT_BIT 2
`define STATUS_STATE_LSB 0
`define STATUS_BOR_BIT 2
`define STATUS_TM0_BIT 3
`define STATUS_TM1_BIT 4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CAUSE_RESET_VAL 5'h02
`define BROWNOUT_CTL_RESET_VAL 2'h0
`define PERIPH_RESET_RESET_VAL 32'h0000_0000
`define SYNC_RESET_VAL 5'h01 // pin sync starts at its idle high level

// ----------------------------------------------------------------------------
// timing: least internal reset width after every source is gone
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define RST_STRETCH_NS 200
`define RST_STRETCH_CYC ((`RST_STRETCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hw/reset_control_pkg.sv
// reset control unit: shared types
// assumes reset_control_defines.svh for all numeric constants
package reset_control_pkg;

  // sequencer states, gray along run -> hold -> stretch -> boot -> run
  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_STRETCH = 2'b11,
    SEQ_BOOT = 2'b10
  } seq_state_e;

  // sticky reset cause flags
  typedef struct packed {
    logic sw;
    logic wdt;
    logic bor;
    logic por;
    logic ext;
  } cause_s;

  // pin samples after synchronising
  typedef struct packed {
    logic tm1;
    logic tm0;
    logic bod;
    logic por;
    logic ext_n;
  } pins_s;

  // whole state of the unit
  typedef struct packed {
    pins_s sync1;
    pins_s sync2;
    seq_state_e seq;
    logic [3:0] cnt;
    cause_s cause;
    logic [1:0] bor_ctl;
    logic [2:0][31:0] periph;
    logic sysreq;
    logic jtag_rst_n;
    logic jtag_pin_rst_n;
    logic bor_irq;
    logic addr_ok;
    logic wr;
    logic [11:0] addr;
    logic [31:0] rdata;
  } rcu_state_s;

endpackage

// ===== hw/reset_control_unit.sv
// reset control unit: gathers reset sources, drives core, tap and peripheral
// resets, keeps the sticky cause register, answers on an AHB-Lite slave port.
// assumes hclk at 25 MHz, hresetn is the supply-level reset of this block
// How it works
// - five sources: pin, power-on, brown-out, software, watchdog
// - power-on resets core, peripherals and tap
// - pin resets core, peripherals, tap pins only
// - other sources skip tap; peripheral reset spares core
// - three peripheral reset registers, one bit each
// - peripheral held in reset while bit set
// - bit order matches clock gating bit order
// - every clock domain reset of unit asserted
// - cause bits record source and are sticky
// - power-on leaves only power-on cause bit
// - hold reset until power-on detector inactive
// - release pulse starts core vector fetch
// - power-on detector only on first power-up
// - brown-out reset off after reset, software enables
// - brown-out gives interrupt or reset per setting
// - brown-out resets only with select bit set
// - brown-out reset held while supply low
// - system reset request bit resets core and peripherals, not tap
// - software reset asserts then releases internal reset
// - cause register readable by software
// - watchdog second time-out asserts reset
`timescale 1ns/1ps
`include "reset_control_defines.svh"

module reset_control_unit #(
  parameter int N_CLK_DOMAINS = 2,
  parameter int N_PERIPH_REGS = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_reset_pin_n,
  input wire logic por_detect,
  input wire logic brownout_detect,
  input wire logic watchdog_reset_req,
  input wire logic test_mode_pin_0,
  input wire logic test_mode_pin_1,
  output logic core_rst_n,
  output logic core_fetch_start,
  output logic jtag_rst_n,
  output logic jtag_pin_rst_n,
  output logic brownout_irq,
  output logic [N_CLK_DOMAINS-1:0][N_PERIPH_REGS*32-1:0] periph_rst_n
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reset_control_pkg::rcu_state_s state_reg;
  reset_control_pkg::rcu_state_s state_next;

  localparam logic [3:0] STRETCH_CYC = 4'(`RST_STRETCH_CYC);

  logic addr_phase;
  logic data_wr;
  logic bor_reset;
  logic ext_reset;
  logic any_source;
  logic internal_rst;
  logic [31:0] rd_mux;
  logic [11:0] rd_addr;

  // bus address phase taken, and write data phase now in progress
  assign addr_phase = hsel && htrans[1] && hready;
  assign data_wr = state_reg.addr_ok && state_reg.wr;

  // pin and detector reset sources seen after the two-flop synchronisers; watchdog request and software bit taken directly
  // held while detector active
  assign bor_reset = state_reg.sync2.bod && state_reg.bor_ctl[`BOR_RESET_SEL_BIT];
  assign ext_reset = !state_reg.sync2.ext_n;
  assign any_source = state_reg.sync2.por || ext_reset || bor_reset || watchdog_reset_req || state_reg.sysreq;
  assign internal_rst = state_reg.seq != reset_control_pkg::SEQ_RUN && state_reg.seq != reset_control_pkg::SEQ_BOOT;
  assign rd_addr = haddr[11:0];

  // --------------------------------------------------------------------------
  // read data selection, evaluated in the address phase
  // --------------------------------------------------------------------------
  // cause register readable
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      `OFS_RESET_CAUSE: rd_mux = {27'h000_0000, state_reg.cause};
      `OFS_BROWNOUT_CTL: rd_mux = {30'h0000_0000, state_reg.bor_ctl};
      `OFS_PERIPH_RESET0: rd_mux = state_reg.periph[0];
      `OFS_PERIPH_RESET1: rd_mux = state_reg.periph[1];
      `OFS_PERIPH_RESET2: rd_mux = state_reg.periph[2];
      `OFS_CORE_IRQ_RESET_CTL: rd_mux = 32'h0000_0000;
      `OFS_STATUS: begin
        rd_mux[`STATUS_STATE_LSB +: 2] = state_reg.seq;
        rd_mux[`STATUS_BOR_BIT] = state_reg.sync2.bod;
        rd_mux[`STATUS_TM0_BIT] = state_reg.sync2.tm0;
        rd_mux[`STATUS_TM1_BIT] = state_reg.sync2.tm1;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // two flops on every pin input
    state_next.sync1 = {test_mode_pin_1, test_mode_pin_0, brownout_detect, por_detect, ext_reset_pin_n};
    state_next.sync2 = state_reg.sync1;

    // bus address phase capture
    state_next.addr_ok = addr_phase;
    state_next.wr = addr_phase && hwrite && hsize == 3'b010;
    state_next.addr = rd_addr;
    if (addr_phase && !hwrite) begin
      state_next.rdata = rd_mux;
    end

    // register writes in the data phase
    if (data_wr) begin
      case (state_reg.addr)
        // cause bits cleared by writing one
        `OFS_RESET_CAUSE: state_next.cause = state_reg.cause & ~hwdata[4:0];
        `OFS_BROWNOUT_CTL: state_next.bor_ctl = hwdata[1:0];
        // same bit order as clock gating
        `OFS_PERIPH_RESET0: state_next.periph[0] = hwdata;
        `OFS_PERIPH_RESET1: state_next.periph[1] = hwdata;
        `OFS_PERIPH_RESET2: state_next.periph[2] = hwdata;
        `OFS_CORE_IRQ_RESET_CTL: state_next.sysreq = hwdata[`SYSTEM_RESET_REQUEST_BIT_BIT];
        default: state_next.sysreq = state_reg.sysreq;
      endcase
    end

    // brown-out raises interrupt when not resetting
    state_next.bor_irq = state_reg.sync2.bod && state_reg.bor_ctl[`BOR_IRQ_EN_BIT] &&
                         !state_reg.bor_ctl[`BOR_RESET_SEL_BIT];

    // sticky cause flags, setting wins over clearing
    if (ext_reset) begin
      state_next.cause.ext = 1'b1;
    end
    if (bor_reset) begin
      state_next.cause.bor = 1'b1;
    end
    if (watchdog_reset_req) begin
      state_next.cause.wdt = 1'b1;
    end
    if (state_reg.sysreq) begin
      state_next.cause.sw = 1'b1;
    end
    // power-on leaves only its own flag
    // detector only fires on first power-up
    if (state_reg.sync2.por) begin
      state_next.cause = '0;
      state_next.cause.por = 1'b1;
    end

    state_next.jtag_rst_n = !state_reg.sync2.por;
    // pin reset touches tap pin setup only
    state_next.jtag_pin_rst_n = !(state_reg.sync2.por || ext_reset);

    // reset sequencer
    case (state_reg.seq)
      reset_control_pkg::SEQ_RUN: begin
        if (any_source) begin
          state_next.seq = reset_control_pkg::SEQ_HOLD;
        end
      end
      // hold until every reset source goes inactive
      reset_control_pkg::SEQ_HOLD: begin
        state_next.cnt = STRETCH_CYC;
        if (!any_source) begin
          state_next.seq = reset_control_pkg::SEQ_STRETCH;
        end
      end
      reset_control_pkg::SEQ_STRETCH: begin
        if (any_source) begin
          state_next.seq = reset_control_pkg::SEQ_HOLD;
        end else if (state_reg.cnt <= 4'h1) begin
          state_next.seq = reset_control_pkg::SEQ_BOOT;
        end else begin
          state_next.cnt = state_reg.cnt - 4'h1;
        end
      end
      reset_control_pkg::SEQ_BOOT: begin
        state_next.seq = any_source ? reset_control_pkg::SEQ_HOLD : reset_control_pkg::SEQ_RUN;
      end
      default: state_next.seq = reset_control_pkg::SEQ_HOLD;
    endcase

    // core-level resets also clear software controls
    // brown-out reset disabled after any reset
    if (internal_rst) begin
      // keep select while brown-out holds reset
      if (!bor_reset) begin
        state_next.bor_ctl = `BROWNOUT_CTL_RESET_VAL;
      end
      state_next.periph = '0;
      state_next.sysreq = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.sync1 <= `SYNC_RESET_VAL;
      state_reg.sync2 <= `SYNC_RESET_VAL;
      state_reg.seq <= reset_control_pkg::SEQ_HOLD;
      state_reg.cnt <= STRETCH_CYC;
      state_reg.cause <= `CAUSE_RESET_VAL;
      state_reg.bor_ctl <= `BROWNOUT_CTL_RESET_VAL;
      state_reg.periph <= '0;
      state_reg.sysreq <= 1'b0;
      state_reg.jtag_rst_n <= 1'b0;
      state_reg.jtag_pin_rst_n <= 1'b0;
      state_reg.bor_irq <= 1'b0;
      state_reg.addr_ok <= 1'b0;
      state_reg.wr <= 1'b0;
      state_reg.addr <= 12'h000;
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;

  // release only on a clock edge
  assign core_rst_n = !internal_rst;
  assign core_fetch_start = state_reg.seq == reset_control_pkg::SEQ_BOOT;
  assign jtag_rst_n = state_reg.jtag_rst_n;
  assign jtag_pin_rst_n = state_reg.jtag_pin_rst_n;
  assign brownout_irq = state_reg.bor_irq;

  // peripheral resets: system reset or the unit's own bit
  genvar d;
  generate
    for (d = 0; d < N_CLK_DOMAINS; d++) begin : g_domain
      // every domain of the unit gets it
      // reset held while software bit set
      assign periph_rst_n[d] = internal_rst ? '0 : ~state_reg.periph[N_PERIPH_REGS-1:0];
    end
  endgenerate

endmodule // reset_control_unit

// ===== sim/reset_control_unit_monitor.sv
// reset control unit: concurrent checks on the top module ports
// assumes the default port set of reset_control_unit and one hclk domain
`timescale 1ns/1ps

module reset_control_unit_monitor #(
  parameter int N_CLK_DOMAINS = 2,
  parameter int N_PERIPH_REGS = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_reset_pin_n,
  input wire logic por_detect,
  input wire logic watchdog_reset_req,
  input wire logic core_rst_n,
  input wire logic core_fetch_start,
  input wire logic jtag_rst_n,
  input wire logic jtag_pin_rst_n,
  input wire logic [N_CLK_DOMAINS-1:0][N_PERIPH_REGS*32-1:0] periph_rst_n
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_fetch;
    $rose(core_rst_n) |-> core_fetch_start ##1 !core_fetch_start;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch pulse wrong");

  property p_stretch;
    $rose(core_rst_n) |-> $past(core_rst_n, 6) == 1'b0;
  endproperty
  a_stretch: assert property (p_stretch) else $error("reset release too early");

  property p_wdt;
    watchdog_reset_req && core_rst_n |=> !core_rst_n;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not reset core");

  property p_pin;
    (!ext_reset_pin_n) [*4] |=> !core_rst_n && !jtag_pin_rst_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset missing");

  property p_por;
    por_detect [*4] |=> !core_rst_n && !jtag_rst_n && !jtag_pin_rst_n;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset incomplete");

  property p_tap_only_por;
    $fell(jtag_rst_n) |-> $past(por_detect, 2) || $past(por_detect, 3) || $past(por_detect, 4);
  endproperty
  a_tap_only_por: assert property (p_tap_only_por) else $error("tap reset without power-on");

  property p_domains;
    periph_rst_n[N_CLK_DOMAINS-1] == periph_rst_n[0];
  endproperty
  a_domains: assert property (p_domains) else $error("clock domains disagree");

  property p_core_periph;
    !core_rst_n |-> periph_rst_n == '0;
  endproperty
  a_core_periph: assert property (p_core_periph) else $error("peripherals left running");

  c_fetch: cover property ($rose(core_rst_n));
  c_wdt: cover property (watchdog_reset_req && core_rst_n);
  c_tap: cover property ($fell(jtag_rst_n));
endmodule // reset_control_unit_monitor

bind reset_control_unit reset_control_unit_monitor #(
  .N_CLK_DOMAINS(N_CLK_DOMAINS),
  .N_PERIPH_REGS(N_PERIPH_REGS)
) u_mon (
  .hclk(hclk),
  .hresetn(hresetn),
  .ext_reset_pin_n(ext_reset_pin_n),
  .por_detect(por_detect),
  .watchdog_reset_req(watchdog_reset_req),
  .core_rst_n(core_rst_n),
  .core_fetch_start(core_fetch_start),
  .jtag_rst_n(jtag_rst_n),
  .jtag_pin_rst_n(jtag_pin_rst_n),
  .periph_rst_n(periph_rst_n)
);

// ===== sim/board_model.sv
// board side of the reset unit: reset pin, supply detectors, test pins
// assumes the caller steps it right after rising hclk edges
`timescale 1ns/1ps

module board_model (
  input wire logic hclk,
  output logic ext_reset_pin_n,
  output logic por_detect,
  output logic brownout_detect,
  output logic test_mode_pin_0,
  output logic test_mode_pin_1
);
  // shortest pin pulse the board may give, in clocks
  localparam int MIN_RESET_PULSE = 4;

  // ----------------------------------------------------------------------
  // levels
  // ----------------------------------------------------------------------
  // test pins grounded
  initial begin
    ext_reset_pin_n = 1'b1;
    por_detect = 1'b0;
    brownout_detect = 1'b0;
    test_mode_pin_0 = 1'b0;
    test_mode_pin_1 = 1'b0;
  end

  // supply detector levels: 1 power-on, 2 brown-out
  task automatic set(input int which, input logic v);
    if (which == 1) begin
      por_detect <= v;
    end else begin
      brownout_detect <= v;
    end
  endtask

  task automatic pin_pulse(input int n);
    ext_reset_pin_n <= 1'b0;
    repeat ((n < MIN_RESET_PULSE) ? MIN_RESET_PULSE : n) @(posedge hclk);
    ext_reset_pin_n <= 1'b1;
  endtask
endmodule // board_model

// ===== sim/tb_reset_control_unit.sv
// testbench of the reset control unit over its AHB-Lite port
// assumes board_model and the bound monitor are compiled before it
`timescale 1ns/1ps
`include "reset_control_defines.svh"

module tb_reset_control_unit;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, watchdog_reset_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic core_rst_n, core_fetch_start, jtag_rst_n, jtag_pin_rst_n, brownout_irq;
  logic ext_reset_pin_n, por_detect, brownout_detect, test_mode_pin_0, test_mode_pin_1;
  logic [1:0][95:0] periph_rst_n;
  int err_count, checked;
  assign hready = hreadyout;

  reset_control_unit uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .ext_reset_pin_n, .por_detect, .brownout_detect, .watchdog_reset_req,
    .test_mode_pin_0, .test_mode_pin_1, .core_rst_n, .core_fetch_start, .jtag_rst_n, .jtag_pin_rst_n,
    .brownout_irq, .periph_rst_n);
  board_model brd (.hclk, .ext_reset_pin_n, .por_detect, .brownout_detect, .test_mode_pin_0, .test_mode_pin_1);

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
    check({hreadyout, hresp}, 2'h2);
  endtask

  task automatic wait_boot;
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge hclk);
      if (core_fetch_start === 1'b1) break;
    end
    check(core_fetch_start, 1'b1);
    @(posedge hclk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end

  initial begin
    {hsel, hwrite, watchdog_reset_req, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    wait_boot();
    rdchk(`OFS_RESET_CAUSE, 32'h0000_0002);
    rdchk(`OFS_BROWNOUT_CTL, 32'h0000_0000);
    rdchk(12'h100, 32'h0000_0000);
    bus(1'b1, `OFS_CORE_IRQ_RESET_CTL, 32'h0000_0004);
    wait_boot();
    rdchk(`OFS_RESET_CAUSE, 32'h0000_0012);
    check(jtag_rst_n, 1'b1);
    watchdog_reset_req <= 1'b1;
    @(posedge hclk);
    watchdog_reset_req <= 1'b0;
    wait_boot();
    rdchk(`OFS_RESET_CAUSE, 32'h0000_001A);
    brd.pin_pulse(2);
    check(jtag_pin_rst_n, 1'b0);
    wait_boot();
    rdchk(`OFS_RESET_CAUSE, 32'h0000_001B);
    check(jtag_rst_n, 1'b1);
    bus(1'b1, `OFS_BROWNOUT_CTL, 32'h0000_0001);
    brd.set(2, 1'b1);
    repeat (6) @(posedge hclk);
    check({brownout_irq, core_rst_n}, 2'h3);
    brd.set(2, 1'b0);
    repeat (6) @(posedge hclk);
    check(brownout_irq, 1'b0);
    bus(1'b1, `OFS_BROWNOUT_CTL, 32'h0000_0002);
    brd.set(2, 1'b1);
    repeat (12) @(posedge hclk);
    check({brownout_irq, core_rst_n}, 2'h0);
    brd.set(2, 1'b0);
    wait_boot();
    bus(1'b0, `OFS_RESET_CAUSE, 32'h0000_0000);
    check(rd[2], 1'b1);
    rdchk(`OFS_BROWNOUT_CTL, 32'h0000_0000);
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, 12'(`OFS_PERIPH_RESET0 + 4 * r), 32'h0000_0001 << (8 * r + 3));
      repeat (2) @(posedge hclk);
      check(periph_rst_n[0], ~(96'(32'h0000_0001) << (40 * r + 3)));
      check(periph_rst_n[1], ~(96'(32'h0000_0001) << (40 * r + 3)));
      check(core_rst_n, 1'b1);
      bus(1'b1, 12'(`OFS_PERIPH_RESET0 + 4 * r), 32'h0000_0000);
      repeat (2) @(posedge hclk);
      check(periph_rst_n[0], ~96'(0));
      check(periph_rst_n[1], ~96'(0));
    end
    brd.set(1, 1'b1);
    repeat (8) @(posedge hclk);
    check({jtag_rst_n, core_rst_n}, 2'h0);
    brd.set(1, 1'b0);
    wait_boot();
    rdchk(`OFS_RESET_CAUSE, 32'h0000_0002);
    bus(1'b1, `OFS_RESET_CAUSE, 32'h0000_0002);
    rdchk(`OFS_RESET_CAUSE, 32'h0000_0000);
    rdchk(`OFS_STATUS, 32'h0000_0000);
    report_and_stop();
  end
endmodule // tb_reset_control_unit
